// ===== rtl/ptt_pkg.sv
// constants, register map and carrier types for the process time-out timer
// assumes a 100 MHz pclk and 32-bit APB data; nothing here holds logic
package ptt_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_PERIOD  = 12'h004;
   localparam logic [11:0] ADDR_STATUS  = 12'h008;
   localparam logic [11:0] ADDR_DISPLAY = 12'h00C;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_ENABLE    = 0;
   localparam int CTRL_MIN_RES   = 1;  // 1: MM:SS, 0: HH:MM
   localparam int CTRL_START_AL  = 2;  // 1: second alarm starts, 0: run/hold key
   localparam int CTRL_ELAPSED   = 3;  // 1: elapsed view, 0: remaining view
   localparam int CTRL_TO_PERIOD = 4;  // 1: freeze on period at time-out, 0: on 00:00
   localparam int CTRL_RESET     = 8;  // write one: timer reset, reads zero
   localparam int LO_POS         = 0;
   localparam int HI_POS         = 8;
   localparam int GLYPH_POS      = 16;
   localparam int STAT_RELAY     = 2;
   localparam int STAT_OWNED     = 3;

   // ---------------------------------------------------------------
   // value ranges and timing
   // ---------------------------------------------------------------
   localparam logic [6:0] HI_MAX     = 7'h63;  // 99
   localparam logic [6:0] LO_MAX_HR  = 7'h3B;  // 59 minutes
   localparam logic [6:0] LO_MAX_MIN = 7'h63;  // 99 seconds
   localparam logic [6:0] LO_WRAP    = 7'h3B;  // running count wraps after 59
   localparam logic [5:0] MIN_LAST   = 6'h3B;  // last second of a minute
   localparam int         CLK_HZ     = 100_000_000;
   localparam int         SECOND_S   = 1;
   localparam int         SEC_CYCLES = CLK_HZ * SECOND_S;
   localparam logic [6:0] FIELD_ZERO = 7'h00;
   localparam logic [6:0] FIELD_ONE  = 7'h01;
   localparam logic [1:0] GLYPH_STEP = 2'h1;

   typedef enum logic [1:0]
   {
      PTT_IDLE    = 2'b00,
      PTT_RUN     = 2'b01,
      PTT_HOLD    = 2'b10,
      PTT_TIMEOUT = 2'b11
   } ptt_state_t;

   // hours:minutes or minutes:seconds pair
   typedef struct packed
   {
      logic [6:0] hi;
      logic [6:0] lo;
   } ptt_time_t;

   typedef struct packed
   {
      logic enable;
      logic min_res;
      logic start_al;
      logic elapsed;
      logic to_period;
   } ptt_cfg_t;
endpackage

// ===== rtl/ptt_timer.sv
// process time-out timer: apb registers, prescaler, counters, relay ownership
// assumes keypad strobes and the second alarm level are synchronous to pclk
`timescale 1ns/1ps

// Overview of operation
// - a time-out period of 0..99:59 in hour mode or 0..99:99 in minute mode is held.
// - a configuration bit picks the run/hold key or the second alarm as the only start.
// - a configuration bit picks a remaining-time or an elapsed-time display.
// - remaining view shows a falling value and a counterclockwise glyph.
// - elapsed view shows a rising value and a clockwise glyph.
// - once enabled and started the timer alone drives the first alarm relay.
// - at time-out the relay is set, the glyph stops and the display freezes as chosen.
// - a reset hands the relay back to the other alarm request, shows the period, allows key trimming, and rearms.
module ptt_timer
#(
   parameter int SEC_CYCLES = ptt_pkg::SEC_CYCLES
)
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // operator keypad and alarm sources
   input  wire logic        run_hold_key,
   input  wire logic        inc_key,
   input  wire logic        dec_key,
   input  wire logic        reset_key,
   input  wire logic        second_alarm_trigger,
   input  wire logic        other_alarm1_req,
   // relay and display
   output logic             alarm1_relay,
   output logic             relay_owned,
   output logic      [6:0]  disp_hi,
   output logic      [6:0]  disp_lo,
   output logic      [1:0]  glyph_phase,
   output logic             glyph_ccw
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   ptt_pkg::ptt_cfg_t   cfg_q;
   ptt_pkg::ptt_time_t  period_q;
   ptt_pkg::ptt_time_t  rem_q;
   ptt_pkg::ptt_time_t  el_q;
   ptt_pkg::ptt_state_t state_q;
   logic [26:0]         sec_cnt_q;
   logic [5:0]          min_cnt_q;
   logic                alarm_q;
   logic [1:0]          glyph_q;

   logic       wr_acc;
   logic       setup;
   logic       sec_tick;
   logic       unit_tick;
   logic       start_ev;
   logic       reset_ev;
   logic       alarm_rise;
   logic [6:0] lo_max;

   assign setup      = psel & ~penable;
   assign wr_acc     = psel & penable & pready & pwrite;
   assign lo_max     = cfg_q.min_res ? ptt_pkg::LO_MAX_MIN : ptt_pkg::LO_MAX_HR;
   assign alarm_rise = second_alarm_trigger & ~alarm_q;
   // only the configured source may start a count
   assign start_ev   = cfg_q.start_al ? alarm_rise : run_hold_key;
   assign reset_ev   = reset_key | (wr_acc & (paddr == ptt_pkg::ADDR_CTRL)
                                   & pwdata[ptt_pkg::CTRL_RESET]);
   // one second from the prescaler; in hour mode sixty of them make a unit
   assign sec_tick   = (sec_cnt_q == 27'(SEC_CYCLES - 1));
   assign unit_tick  = sec_tick & (cfg_q.min_res | (min_cnt_q == ptt_pkg::MIN_LAST));

   // ---------------------------------------------------------------
   // apb slave: answers in the first access cycle, no wait states
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~(paddr == ptt_pkg::ADDR_CTRL || paddr == ptt_pkg::ADDR_PERIOD ||
                              paddr == ptt_pkg::ADDR_STATUS || paddr == ptt_pkg::ADDR_DISPLAY);
         prdata  <= 32'h0000_0000;
         if (setup && !pwrite)
         begin
            unique case (paddr)
               ptt_pkg::ADDR_CTRL:    prdata <= {27'h0, cfg_q.to_period, cfg_q.elapsed,
                                                 cfg_q.start_al, cfg_q.min_res, cfg_q.enable};
               ptt_pkg::ADDR_PERIOD:  prdata <= {17'h0, period_q.hi, 1'b0, period_q.lo};
               ptt_pkg::ADDR_STATUS:  prdata <= {28'h0, relay_owned, alarm1_relay, state_q};
               ptt_pkg::ADDR_DISPLAY: prdata <= {14'h0, glyph_phase, 1'b0, disp_hi,
                                                 1'b0, disp_lo};
               default:               prdata <= 32'h0000_0000; // unmapped reads zero
            endcase
         end
      end
   end

   // configuration, software sets it before use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_q <= '0;
      else if (wr_acc && paddr == ptt_pkg::ADDR_CTRL)
      begin
         cfg_q.enable    <= pwdata[ptt_pkg::CTRL_ENABLE];
         cfg_q.min_res   <= pwdata[ptt_pkg::CTRL_MIN_RES];
         cfg_q.start_al  <= pwdata[ptt_pkg::CTRL_START_AL];
         cfg_q.elapsed   <= pwdata[ptt_pkg::CTRL_ELAPSED];
         cfg_q.to_period <= pwdata[ptt_pkg::CTRL_TO_PERIOD];
      end
   end

   // period: writable and trimmable only while idle, clamped to the range
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         period_q <= '0;
      else if (state_q == ptt_pkg::PTT_IDLE)
      begin
         if (wr_acc && paddr == ptt_pkg::ADDR_PERIOD)
         begin
            period_q.hi <= (pwdata[14:8] > ptt_pkg::HI_MAX) ? ptt_pkg::HI_MAX : pwdata[14:8];
            period_q.lo <= (pwdata[6:0] > lo_max) ? lo_max : pwdata[6:0];
         end
         else if (inc_key && !dec_key)
         begin
            if (period_q.lo < lo_max)
               period_q.lo <= period_q.lo + ptt_pkg::FIELD_ONE;
            else if (period_q.hi < ptt_pkg::HI_MAX)
            begin
               period_q.lo <= ptt_pkg::FIELD_ZERO;
               period_q.hi <= period_q.hi + ptt_pkg::FIELD_ONE;
            end
         end
         else if (dec_key && !inc_key)
         begin
            if (period_q.lo != ptt_pkg::FIELD_ZERO)
               period_q.lo <= period_q.lo - ptt_pkg::FIELD_ONE;
            else if (period_q.hi != ptt_pkg::FIELD_ZERO)
            begin
               period_q.lo <= lo_max;
               period_q.hi <= period_q.hi - ptt_pkg::FIELD_ONE;
            end
         end
         else if (period_q.lo > lo_max)
            period_q.lo <= lo_max; // resolution changed under a 99 second field
      end
   end

   // ---------------------------------------------------------------
   // sequencing: idle, run, hold, time-out
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_q <= ptt_pkg::PTT_IDLE;
      else if (!cfg_q.enable || reset_ev)
         state_q <= ptt_pkg::PTT_IDLE;
      else
      begin
         unique case (state_q)
            ptt_pkg::PTT_IDLE:
               if (start_ev)
                  state_q <= ptt_pkg::PTT_RUN;
            ptt_pkg::PTT_RUN:
               if (rem_q == '0)
                  state_q <= ptt_pkg::PTT_TIMEOUT;
               else if (run_hold_key && !cfg_q.start_al)
                  state_q <= ptt_pkg::PTT_HOLD;
            ptt_pkg::PTT_HOLD:
               if (run_hold_key)
                  state_q <= ptt_pkg::PTT_RUN;
            ptt_pkg::PTT_TIMEOUT:
               state_q <= ptt_pkg::PTT_TIMEOUT; // waits for a reset
         endcase
      end
   end

   // prescaler, cleared while idle so each start gets full units, held during hold and time-out
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sec_cnt_q <= 27'h0000000;
         min_cnt_q <= 6'h00;
      end
      else if (state_q == ptt_pkg::PTT_IDLE)
      begin
         sec_cnt_q <= 27'h0000000;
         min_cnt_q <= 6'h00;
      end
      else if (state_q == ptt_pkg::PTT_RUN)
      begin
         sec_cnt_q <= sec_tick ? 27'h0000000 : sec_cnt_q + 27'h0000001;
         if (sec_tick)
            min_cnt_q <= (min_cnt_q == ptt_pkg::MIN_LAST) ? 6'h00 : min_cnt_q + 6'h01;
      end
   end

   // remaining counts down from the period, elapsed counts up from zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rem_q <= '0;
         el_q  <= '0;
      end
      else if (state_q == ptt_pkg::PTT_IDLE)
      begin
         rem_q <= period_q;
         el_q  <= '0;
      end
      else if (state_q == ptt_pkg::PTT_RUN && unit_tick && rem_q != '0)
      begin
         if (rem_q.lo == ptt_pkg::FIELD_ZERO)
         begin
            rem_q.lo <= ptt_pkg::LO_WRAP;
            rem_q.hi <= rem_q.hi - ptt_pkg::FIELD_ONE;
         end
         else
            rem_q.lo <= rem_q.lo - ptt_pkg::FIELD_ONE;
         if (el_q.lo == ptt_pkg::LO_WRAP)
         begin
            el_q.lo <= ptt_pkg::FIELD_ZERO;
            el_q.hi <= el_q.hi + ptt_pkg::FIELD_ONE;
         end
         else
            el_q.lo <= el_q.lo + ptt_pkg::FIELD_ONE;
      end
   end

   // glyph steps once per unit while running and stands still otherwise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         glyph_q <= 2'h0;
      else if (state_q == ptt_pkg::PTT_RUN && unit_tick)
         glyph_q <= cfg_q.elapsed ? glyph_q + ptt_pkg::GLYPH_STEP
                                  : glyph_q - ptt_pkg::GLYPH_STEP;
   end

   // ---------------------------------------------------------------
   // outputs, all registered
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alarm_q      <= 1'b0;
         alarm1_relay <= 1'b0;
         relay_owned  <= 1'b0;
         disp_hi      <= 7'h00;
         disp_lo      <= 7'h00;
         glyph_phase  <= 2'h0;
         glyph_ccw    <= 1'b0;
      end
      else
      begin
         alarm_q     <= second_alarm_trigger;
         // the other alarm function is locked out while the timer owns the relay
         relay_owned <= cfg_q.enable && state_q != ptt_pkg::PTT_IDLE;
         if (cfg_q.enable && state_q != ptt_pkg::PTT_IDLE)
            alarm1_relay <= (state_q == ptt_pkg::PTT_TIMEOUT);
         else
            alarm1_relay <= other_alarm1_req;
         glyph_phase <= glyph_q;
         glyph_ccw   <= ~cfg_q.elapsed;
         unique case (state_q)
            ptt_pkg::PTT_IDLE:
               {disp_hi, disp_lo} <= period_q;
            ptt_pkg::PTT_TIMEOUT:
               {disp_hi, disp_lo} <= cfg_q.to_period ? period_q : '0;
            default:
               {disp_hi, disp_lo} <= cfg_q.elapsed ? el_q : rem_q;
         endcase
      end
   end
endmodule // ptt_timer

// ===== bench/ptt_timer_assertions.sv
// checker for the time-out timer ports, bound into every ptt_timer
// assumes an apb master that drops penable right after pready
`timescale 1ns/1ps
module ptt_timer_assertions
(
   // clock, reset and apb
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // keypad, alarms, relay and display
   input wire logic        run_hold_key, inc_key, dec_key, reset_key, glyph_ccw,
   input wire logic        second_alarm_trigger, other_alarm1_req, alarm1_relay, relay_owned,
   input wire logic [6:0]  disp_hi, disp_lo,
   input wire logic [1:0]  glyph_phase
);
   // ------------------------------------------------------------
   // helpers: setup phase, mapped word, timer parked at time-out
   // ------------------------------------------------------------
   logic setup, mapped, parked;
   assign setup  = psel && !penable;
   assign mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
   assign parked = alarm1_relay && relay_owned;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // apb answers: zero wait, one cycle, error only off the map
   a_ready_next: assert property (setup |=> pready)
      else $error("pready late");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready held");
   a_err_unmapped: assert property (setup && !mapped |=> pslverr && pready)
      else $error("unmapped access not flagged");
   a_ok_mapped: assert property (setup && mapped |=> !pslverr)
      else $error("mapped access flagged");
   a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside a read");
   // relay follows the normal request only once the timer has let go for a while
   a_relay_follow: assert property (!relay_owned [*3] |-> alarm1_relay == $past(other_alarm1_req))
      else $error("relay not following alarm request");
   // parked at time-out: glyph and display stand still
   a_glyph_stop: assert property (parked [*3] |-> $stable(glyph_phase))
      else $error("glyph moves at time-out");
   a_disp_frozen: assert property (parked [*3] |-> $stable(disp_hi) && $stable(disp_lo))
      else $error("display moves at time-out");
   a_disp_range: assert property (disp_hi <= 7'h63 && disp_lo <= 7'h63)
      else $error("display field out of range");
endmodule // ptt_timer_assertions

bind ptt_timer ptt_timer_assertions u_ptt_timer_assertions (.*);

// ===== bench/ptt_partner.sv
// keypad and alarm source model for the time-out timer
// assumes callers enter its tasks just after a rising pclk edge
`timescale 1ns/1ps
module ptt_partner
(
   // clock
   input  wire logic pclk,
   // keys and alarm levels
   output logic      run_hold_key,
   output logic      inc_key,
   output logic      dec_key,
   output logic      reset_key,
   output logic      second_alarm_trigger,
   output logic      other_alarm1_req
);
   // quiet keypad at time zero so reset sees clean inputs
   initial
   begin
      {run_hold_key, inc_key, dec_key, reset_key} = 4'h0;
      second_alarm_trigger = 1'b0;
      other_alarm1_req = 1'b0;
   end
   // one-cycle press, then a spare edge so two presses never merge
   task automatic press(logic [3:0] keys);
      {run_hold_key, inc_key, dec_key, reset_key} <= keys;
      @(posedge pclk);
      {run_hold_key, inc_key, dec_key, reset_key} <= 4'h0;
      @(posedge pclk);
   endtask
   // alarm levels change only just after an edge
   task automatic level(logic al, logic oth);
      second_alarm_trigger <= al;
      other_alarm1_req <= oth;
   endtask
endmodule // ptt_partner

// ===== bench/ptt_timer_bench.sv
// self-checking bench for the time-out timer: apb master, one task per scenario
// assumes the keypad partner and the bound checker; one second is SEC cycles
`timescale 1ns/1ps
module ptt_timer_bench;
   // ------------------------------------------------------------
   // nets carry the port names so instances connect by name
   // ------------------------------------------------------------
   localparam int SEC = 4;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, run_hold_key, inc_key, dec_key, reset_key, glyph_ccw;
   logic        second_alarm_trigger, other_alarm1_req, alarm1_relay, relay_owned;
   logic [6:0]  disp_hi, disp_lo;
   logic [1:0]  glyph_phase;
   int          bad_count = 0, tests_run = 0;

   ptt_timer #(.SEC_CYCLES(SEC)) u_ptt_timer (.*);
   ptt_partner u_ptt_partner (.*);

   // 100 MHz pclk
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // apb transfer; changes just after a rising edge, pready and data taken at a rising edge
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // the request stands until pready is seen or the bound of 20 edges runs out
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      if (pready !== 1'b1)
         summarize();
      rd = prdata;
      chk("pslverr", {31'h0, a > 12'h00C}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      // a spare edge keeps the next setup out of this time step
      @(posedge pclk);
   endtask
   // bounded wait for the display pair or the relay level
   task automatic wait_for(logic rly, logic [13:0] exp, int lim);
      int          n;
      logic [13:0] got;
      n = 0;
      do
      begin
         @(negedge pclk);
         got = rly ? {13'h0, alarm1_relay} : {disp_hi, disp_lo};
         n++;
      end
      while (got !== exp && n < lim);
      chk(rly ? "relay" : "display", {18'h0, exp}, {18'h0, got});
      if (got !== exp)
         summarize();
      @(posedge pclk);
   endtask
   task automatic see(logic [13:0] exp);
      wait_for(1'b0, exp, 1);
   endtask
   // ctrl words: 1 enable, 2 mm:ss, 4 alarm start, 8 elapsed, 10 period at end
   task automatic t_regs();
      apb(1'b1, 12'h010, 32'hFF);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", 32'h0, rd);
      apb(1'b1, ptt_pkg::ADDR_PERIOD, 32'h7F7F);
      apb(1'b0, ptt_pkg::ADDR_PERIOD, 32'h0);
      chk("period", 32'h633B, rd);
      apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h3);
      apb(1'b0, ptt_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h3, rd);
      apb(1'b1, ptt_pkg::ADDR_PERIOD, 32'h7F7F);
      see(14'h31E3);
      $display("test regs done");
   endtask
   // key start and hold, count down to 00:00, reset, trim
   task automatic t_remain();
      apb(1'b1, ptt_pkg::ADDR_PERIOD, 32'h2);
      u_ptt_partner.level(1'b1, 1'b0);
      repeat (2 * SEC) @(posedge pclk);
      see(14'h2);
      u_ptt_partner.press(4'h8);
      u_ptt_partner.press(4'h8);
      apb(1'b0, ptt_pkg::ADDR_STATUS, 32'h0);
      chk("status", 32'hA, rd);
      u_ptt_partner.press(4'h8);
      wait_for(1'b0, 14'h1, SEC + 4);
      chk("glyph_ccw", 32'h1, {31'h0, glyph_ccw});
      chk("glyph", 32'h3, {30'h0, glyph_phase});
      wait_for(1'b1, 14'h1, SEC + 6);
      see(14'h0);
      u_ptt_partner.press(4'h1);
      wait_for(1'b1, 14'h0, 4);
      see(14'h2);
      u_ptt_partner.press(4'h4);
      see(14'h3);
      u_ptt_partner.press(4'h2);
      see(14'h2);
      u_ptt_partner.press(4'h6);
      see(14'h2);
      u_ptt_partner.press(4'h4);
      see(14'h3);
      $display("test remaining done");
   endtask
   // alarm start, rising count, relay kept from the normal request
   task automatic t_elapse();
      u_ptt_partner.level(1'b0, 1'b1);
      apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h1F);
      wait_for(1'b1, 14'h1, 4);
      u_ptt_partner.press(4'h8);
      see(14'h3);
      u_ptt_partner.level(1'b1, 1'b1);
      wait_for(1'b0, 14'h1, SEC + 6);
      chk("relay", 32'h0, {31'h0, alarm1_relay});
      chk("glyph_ccw", 32'h0, {31'h0, glyph_ccw});
      chk("glyph", 32'h3, {30'h0, glyph_phase});
      wait_for(1'b0, 14'h3, 2 * SEC + 6);
      chk("glyph", 32'h1, {30'h0, glyph_phase});
      wait_for(1'b1, 14'h1, 6);
      u_ptt_partner.level(1'b0, 1'b0);
      apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h0);
      wait_for(1'b1, 14'h0, 4);
      $display("test elapsed done");
   endtask
   // hour mode: minutes move once a minute; period shown at time-out
   task automatic t_hour();
      apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h11);
      apb(1'b1, ptt_pkg::ADDR_PERIOD, 32'h1);
      u_ptt_partner.press(4'h8);
      repeat (50 * SEC) @(posedge pclk);
      see(14'h1);
      wait_for(1'b1, 14'h1, 20 * SEC);
      see(14'h1);
      // glyph took one counterclockwise step from 1; period shown, 0:01
      apb(1'b0, ptt_pkg::ADDR_DISPLAY, 32'h0);
      chk("display reg", 32'h1, rd);
      apb(1'b1, ptt_pkg::ADDR_CTRL, 32'h111);
      wait_for(1'b1, 14'h0, 4);
      apb(1'b0, ptt_pkg::ADDR_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      $display("test hour done");
   endtask
   // reset for sixteen cycles, then the scenarios in turn
   initial
   begin
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h000;
      pwdata <= 32'h0000_0000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_remain();
      t_elapse();
      t_hour();
      summarize();
   end
endmodule // ptt_timer_bench
